// [design/sst_pkg.sv]
// constants, field layouts and states of the subtract / table-read datapath
// assumes one 100 MHz core clock and a classic wishbone register port
package sst_pkg;
  // =====================================================================
  // register map, byte addresses on a 32-bit wishbone port
  localparam logic [7:0] REG_STAT = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_TEMP_MULTIPLICAND_REG = 8'h08;
  localparam logic [7:0] REG_INSN = 8'h0C;
  localparam logic [7:0] REG_RPT = 8'h10;
  localparam logic [7:0] REG_PC = 8'h14;
  localparam logic [7:0] REG_ARP = 8'h18;
  localparam logic [7:0] REG_MCFG = 8'h1C;
  localparam logic [7:0] REG_MADDR = 8'h20;
  localparam logic [7:0] REG_PDAT = 8'h24;
  localparam logic [7:0] REG_DDAT = 8'h28;
  localparam logic [7:0] REG_MSTK = 8'h2C;
  localparam logic [7:0] REG_DP = 8'h30;
  localparam logic [7:0] REG_AR_BASE = 8'h40;
  localparam logic [7:0] AR_MASK = 8'hE0;
  localparam int AR_IDX_LSB = 2;
  localparam int AR_IDX_MSB = 4;
  localparam int BYTE_W = 8;
  // =====================================================================
  // sizes
  localparam int PMEM_AW = 8;
  localparam int DMEM_AW = 9;
  localparam int DP_W = 2;
  localparam int CNT_W = 5;
  localparam int RPT_W = 8;
  localparam int SHIFT_W = 4;
  // =====================================================================
  // opcodes (upper byte) and pointer update codes
  localparam logic [7:0] OP_SUB_UNSIGNED_OP = 8'h66;
  localparam logic [7:0] OP_SUB_SHIFTED_OP = 8'h67;
  localparam logic [7:0] OP_TABLE_READ_OP = 8'hA6;
  localparam logic [2:0] ARU_NONE = 3'h0;
  localparam logic [2:0] ARU_DEC = 3'h1;
  localparam logic [2:0] ARU_INC = 3'h2;
  localparam logic [2:0] ARU_BRSUB = 3'h4;
  localparam logic [2:0] ARU_IDXSUB = 3'h5;
  localparam logic [2:0] ARU_IDXADD = 3'h6;
  localparam logic [2:0] ARU_BRADD = 3'h7;
  localparam logic [31:0] ACC_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] ACC_MIN = 32'h80000000;
  // =====================================================================
  // carriers
  typedef struct packed {
    logic [7:0] op;
    logic ind;
    logic [2:0] pointer_update_code;
    logic nsel;
    logic [2:0] next_pointer_select;
  } sst_insn_t;
  typedef struct packed {
    logic illegal;
    logic busy;
    logic ov;
    logic carry;
    logic saturate_on_exceed;
    logic sign_extend_select;
  } sst_stat_t;
  typedef struct packed {
    logic shared;
    logic code_ext;
    logic opnd_ext;
    logic [3:0] code_wait;
    logic [3:0] data_wait;
  } sst_mcfg_t;
  typedef enum logic [2:0] {S_IDLE, S_SUBW, S_TOVH, S_TRD, S_TWR, S_TEND} sst_state_t;
endpackage

// [design/sst_subalu.sv]
// shifted subtract with borrow, overflow and saturation
// assumes the caller registers the result; purely combinational
module sst_subalu (
  input wire logic [31:0] i_acc,
  input wire logic [15:0] i_data,
  input wire logic [sst_pkg::SHIFT_W-1:0] i_shift,
  input wire logic i_sext,
  input wire logic i_ovm,
  output logic [31:0] o_result,
  output logic o_carry,
  output logic o_ovf
);
  logic [31:0] opnd;
  logic [32:0] diff;

  // =====================================================================
  // extend, shift, subtract, clamp
  always_comb begin
    opnd = i_sext ? {{16{i_data[15]}}, i_data} : {16'h0000, i_data};
    opnd = opnd << i_shift;
    diff = {1'b0, i_acc} - {1'b0, opnd};
    o_carry = ~diff[32]; // borrow clears carry
    o_ovf = (i_acc[31] != opnd[31]) && (diff[31] != i_acc[31]);
    o_result = diff[31:0];
    if (o_ovf && i_ovm) begin
      o_result = i_acc[31] ? sst_pkg::ACC_MIN : sst_pkg::ACC_MAX;
    end
  end
endmodule

// [design/sst_arunit.sv]
// auxiliary pointer update: step, index add/sub, bit-reversed add/sub
// assumes the index comes from pointer 0
module sst_arunit (
  input wire logic [15:0] i_ar,
  input wire logic [15:0] i_idx,
  input wire logic [2:0] i_code,
  output logic [15:0] o_ar
);
  logic [15:0] rev_ar;
  logic [15:0] rev_idx;
  logic [15:0] rev_sum;

  // =====================================================================
  // bit-reversed forms carry from msb toward lsb
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rev_ar[i] = i_ar[15-i];
      rev_idx[i] = i_idx[15-i];
    end
    rev_sum = (i_code == sst_pkg::ARU_BRADD) ? rev_ar + rev_idx : rev_ar - rev_idx;
    case (i_code) // seven modes
      sst_pkg::ARU_DEC: o_ar = i_ar - 16'h0001;
      sst_pkg::ARU_INC: o_ar = i_ar + 16'h0001;
      sst_pkg::ARU_IDXSUB: o_ar = i_ar - i_idx;
      sst_pkg::ARU_IDXADD: o_ar = i_ar + i_idx;
      sst_pkg::ARU_BRADD, sst_pkg::ARU_BRSUB: begin
        for (int i = 0; i < 16; i++) begin
          o_ar[i] = rev_sum[15-i];
        end
      end
      default: o_ar = i_ar;
    endcase
  end
endmodule

// [design/sst_core.sv]
// shifted/unsigned subtract and table-read execution unit with its memories
// assumes classic wishbone master, synchronous active-low reset, one clock
// Behaviour
// - shifted subtract shifts the data word left by temp_multiplicand_reg[3:0] and subtracts it from the accumulator.
// - for shifted subtract the data word is sign-extended when sign_extend_select is 1, zero-extended when 0.
// - carry is cleared on a borrow and set when no borrow occurs.
// - shifted subtract updates carry and sum_exceeded_flag and honours saturate_on_exceed and sign extension.
// - direct form is opcode 01100111 with bit 7 clear, bits 6..0 giving the low address bits.
// - indirect form supports seven pointer updates and an optional next pointer 0..7.
// - single subtract takes 1 cycle, 2 when sharing single_access_ram, plus external waits.
// - repeated shifted subtract takes n cycles plus shared-block and external overheads.
// - repeated unsigned subtract follows the same n, n+1, n+nd, n+1+p+nd timing.
// - table read sources program memory at acc[15:0] and writes the addressed data word.
// - each word is read from program memory before it is written to data memory.
// - table read saves pc+1 in micro_return_store, runs pc from acc and restores it at the end.
// - a repeated table read moves one word per cycle, decrementing the repeat count while nonzero.
// - indirect table read updates the pointer and pointer_select once per word.
// - unsigned subtract zero-extends the data word regardless of sign_extend_select.
// - single on-chip table read takes 3 cycles, with external waits added on top.
module sst_core (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic o_busy
);
  // =====================================================================
  // state
  sst_pkg::sst_state_t st, next_st;
  sst_pkg::sst_insn_t insn, next_insn;
  sst_pkg::sst_stat_t stat, next_stat;
  sst_pkg::sst_mcfg_t mcfg, next_mcfg;
  logic [31:0] acc, next_acc;
  logic [15:0] temp_multiplicand_reg, next_temp_multiplicand_reg;
  logic [15:0] pc, next_pc;
  logic [15:0] mstk, next_mstk;
  logic [15:0] maddr, next_maddr;
  logic [15:0] tword, next_tword;
  logic [sst_pkg::RPT_W-1:0] repeat_prefix, next_rpt;
  logic [sst_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [2:0] pointer_select, next_arp;
  logic [sst_pkg::DP_W-1:0] dp, next_dp;
  logic [15:0] ar [8];
  logic [15:0] next_ar [8];
  logic [15:0] pmem [1<<sst_pkg::PMEM_AW];
  logic [15:0] dmem [1<<sst_pkg::DMEM_AW];
  logic ack, next_ack, next_busy;
  logic [31:0] rdat, next_rdat;
  logic hit, wr, dwe, pwe;
  logic [sst_pkg::DMEM_AW-1:0] daddr, dwaddr;
  logic [15:0] dwdata, dword, ar_new;
  logic [31:0] alu_res;
  logic alu_c, alu_ovf, is_sub_shifted_op, is_sub, exec_sub;
  logic [sst_pkg::CNT_W-1:0] per_m1, sub_ovh, code_w, src_w;
  logic [2:0] ar_idx;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    wmerge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        wmerge[b*sst_pkg::BYTE_W +: sst_pkg::BYTE_W] = nw[b*sst_pkg::BYTE_W +: sst_pkg::BYTE_W];
      end
    end
  endfunction

  // =====================================================================
  // decode helpers and datapath instances
  assign hit = i_wb_cyc && i_wb_stb && !ack;
  assign wr = hit && i_wb_we && (st == sst_pkg::S_IDLE); // writes while busy are dropped
  assign ar_idx = i_wb_adr[sst_pkg::AR_IDX_MSB:sst_pkg::AR_IDX_LSB];
  assign is_sub_shifted_op = insn.op == sst_pkg::OP_SUB_SHIFTED_OP;
  assign is_sub = is_sub_shifted_op || (insn.op == sst_pkg::OP_SUB_UNSIGNED_OP);
  assign daddr = insn.ind ? ar[pointer_select][sst_pkg::DMEM_AW-1:0] : {dp, insn.pointer_update_code, insn.nsel, insn.next_pointer_select};
  assign dword = dmem[daddr];
  assign exec_sub = (st == sst_pkg::S_SUBW) && (cnt == '0);
  // per-word operand wait and one-time overhead
  assign code_w = mcfg.code_ext ? sst_pkg::CNT_W'(mcfg.code_wait) : '0;
  assign src_w = mcfg.opnd_ext ? sst_pkg::CNT_W'(mcfg.data_wait) : '0;
  assign per_m1 = src_w;
  assign sub_ovh = mcfg.shared ? sst_pkg::CNT_W'(1) :
    (code_w + ((mcfg.code_ext && mcfg.opnd_ext) ? sst_pkg::CNT_W'(1) : '0));

  sst_subalu u_alu (
    .i_acc(acc),
    .i_data(dword),
    .i_shift(is_sub_shifted_op ? temp_multiplicand_reg[sst_pkg::SHIFT_W-1:0] : '0),
    .i_sext(is_sub_shifted_op && stat.sign_extend_select), // unsigned form ignores the select
    .i_ovm(stat.saturate_on_exceed),
    .o_result(alu_res),
    .o_carry(alu_c),
    .o_ovf(alu_ovf)
  );

  sst_arunit u_ar (
    .i_ar(ar[pointer_select]),
    .i_idx(ar[0]),
    .i_code(insn.pointer_update_code),
    .o_ar(ar_new)
  );

  // =====================================================================
  // next state: bus writes while idle, then the execution sequencer
  always_comb begin
    next_st = st;
    next_insn = insn;
    next_stat = stat;
    next_mcfg = mcfg;
    next_acc = acc;
    next_temp_multiplicand_reg = temp_multiplicand_reg;
    next_pc = pc;
    next_mstk = mstk;
    next_maddr = maddr;
    next_tword = tword;
    next_rpt = repeat_prefix;
    next_cnt = cnt;
    next_arp = pointer_select;
    next_dp = dp;
    next_ar = ar;
    dwe = 1'b0;
    pwe = 1'b0;
    dwaddr = maddr[sst_pkg::DMEM_AW-1:0];
    dwdata = i_wb_dat[15:0];
    if (wr) begin
      case (i_wb_adr)
        sst_pkg::REG_STAT: next_stat = $bits(sst_pkg::sst_stat_t)'(wmerge(32'(stat), i_wb_dat, i_wb_sel));
        sst_pkg::REG_ACC: next_acc = wmerge(acc, i_wb_dat, i_wb_sel);
        sst_pkg::REG_TEMP_MULTIPLICAND_REG: next_temp_multiplicand_reg = i_wb_dat[15:0];
        sst_pkg::REG_RPT: next_rpt = i_wb_dat[sst_pkg::RPT_W-1:0];
        sst_pkg::REG_PC: next_pc = i_wb_dat[15:0];
        sst_pkg::REG_ARP: next_arp = i_wb_dat[2:0];
        sst_pkg::REG_MCFG: next_mcfg = i_wb_dat[$bits(sst_pkg::sst_mcfg_t)-1:0];
        sst_pkg::REG_MADDR: next_maddr = i_wb_dat[15:0];
        sst_pkg::REG_PDAT: pwe = 1'b1;
        sst_pkg::REG_DDAT: dwe = 1'b1;
        sst_pkg::REG_DP: next_dp = i_wb_dat[sst_pkg::DP_W-1:0];
        sst_pkg::REG_INSN: begin
          next_insn = i_wb_dat[15:0]; // one 16-bit word
          next_stat.illegal = 1'b0;
          if (next_insn.op == sst_pkg::OP_SUB_SHIFTED_OP || next_insn.op == sst_pkg::OP_SUB_UNSIGNED_OP) begin
            next_st = sst_pkg::S_SUBW;
            next_cnt = sub_ovh + per_m1;
          end else if (next_insn.op == sst_pkg::OP_TABLE_READ_OP) begin
            next_mstk = pc + 16'h0001;
            next_pc = acc[15:0];
            // code wait only when the code is external, else straight to the read
            next_cnt = code_w - sst_pkg::CNT_W'(1);
            next_st = (code_w == '0) ? sst_pkg::S_TRD : sst_pkg::S_TOVH;
          end else begin
            next_stat.illegal = 1'b1;
          end
        end
        default: begin
          if ((i_wb_adr & sst_pkg::AR_MASK) == sst_pkg::REG_AR_BASE) begin
            next_ar[ar_idx] = i_wb_dat[15:0];
          end
        end
      endcase
    end
    case (st)
      sst_pkg::S_IDLE: begin
      end
      sst_pkg::S_SUBW: begin
        if (cnt != '0) begin
          next_cnt = cnt - sst_pkg::CNT_W'(1);
        end else begin
          next_acc = alu_res;
          next_stat.carry = alu_c;
          next_stat.ov = stat.ov | alu_ovf; // sticky until software clears
          if (insn.ind) begin
            next_ar[pointer_select] = ar_new;
            if (insn.nsel) begin
              next_arp = insn.next_pointer_select;
            end
          end
          if (repeat_prefix != '0) begin
            next_rpt = repeat_prefix - sst_pkg::RPT_W'(1);
            next_cnt = per_m1;
          end else begin
            next_st = sst_pkg::S_IDLE;
          end
        end
      end
      sst_pkg::S_TOVH: begin
        if (cnt != '0) begin
          next_cnt = cnt - sst_pkg::CNT_W'(1);
        end else begin
          next_st = sst_pkg::S_TRD;
        end
      end
      sst_pkg::S_TRD: begin
        next_tword = pmem[pc[sst_pkg::PMEM_AW-1:0]]; // read first
        next_cnt = src_w;
        next_st = sst_pkg::S_TWR;
      end
      sst_pkg::S_TWR: begin
        if (cnt != '0) begin
          next_cnt = cnt - sst_pkg::CNT_W'(1);
        end else begin
          dwe = 1'b1; // write after the read
          dwaddr = daddr;
          dwdata = tword;
          next_pc = pc + 16'h0001;
          if (insn.ind) begin
            next_ar[pointer_select] = ar_new; // once per word
            if (insn.nsel) begin
              next_arp = insn.next_pointer_select;
            end
          end
          if (repeat_prefix != '0) begin
            // overlap the next read with this write: one word per cycle
            next_rpt = repeat_prefix - sst_pkg::RPT_W'(1);
            next_tword = pmem[next_pc[sst_pkg::PMEM_AW-1:0]];
            next_cnt = src_w;
          end else begin
            next_st = sst_pkg::S_TEND;
          end
        end
      end
      sst_pkg::S_TEND: begin
        next_pc = mstk;
        next_st = sst_pkg::S_IDLE;
      end
      default: next_st = sst_pkg::S_IDLE;
    endcase
    next_stat.busy = next_st != sst_pkg::S_IDLE;
  end

  // =====================================================================
  // architectural registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st <= sst_pkg::S_IDLE;
      insn <= '0;
      stat <= '0;
      mcfg <= '0;
      acc <= '0;
      temp_multiplicand_reg <= '0;
      pc <= '0;
      mstk <= '0;
      maddr <= '0;
      tword <= '0;
      repeat_prefix <= '0;
      cnt <= '0;
      pointer_select <= '0;
      dp <= '0;
      for (int i = 0; i < 8; i++) begin
        ar[i] <= '0;
      end
    end else begin
      st <= next_st;
      insn <= next_insn;
      stat <= next_stat;
      mcfg <= next_mcfg;
      acc <= next_acc;
      temp_multiplicand_reg <= next_temp_multiplicand_reg;
      pc <= next_pc;
      mstk <= next_mstk;
      maddr <= next_maddr;
      tword <= next_tword;
      repeat_prefix <= next_rpt;
      cnt <= next_cnt;
      pointer_select <= next_arp;
      dp <= next_dp;
      ar <= next_ar;
    end
  end

  // memories keep contents across reset
  always_ff @(posedge i_core_clk) begin
    if (pwe) begin
      pmem[maddr[sst_pkg::PMEM_AW-1:0]] <= i_wb_dat[15:0];
    end
    if (dwe) begin
      dmem[dwaddr] <= dwdata;
    end
  end

  // =====================================================================
  // wishbone answer: ack and data one cycle after the request
  always_comb begin
    next_ack = hit;
    next_busy = next_st != sst_pkg::S_IDLE;
    next_rdat = rdat;
    if (hit) begin
      case (i_wb_adr)
        sst_pkg::REG_STAT: next_rdat = 32'(stat);
        sst_pkg::REG_ACC: next_rdat = acc;
        sst_pkg::REG_TEMP_MULTIPLICAND_REG: next_rdat = 32'(temp_multiplicand_reg);
        sst_pkg::REG_INSN: next_rdat = 32'(insn);
        sst_pkg::REG_RPT: next_rdat = 32'(repeat_prefix);
        sst_pkg::REG_PC: next_rdat = 32'(pc);
        sst_pkg::REG_ARP: next_rdat = 32'(pointer_select);
        sst_pkg::REG_MCFG: next_rdat = 32'(mcfg);
        sst_pkg::REG_MADDR: next_rdat = 32'(maddr);
        sst_pkg::REG_PDAT: next_rdat = 32'(pmem[maddr[sst_pkg::PMEM_AW-1:0]]);
        sst_pkg::REG_DDAT: next_rdat = 32'(dmem[maddr[sst_pkg::DMEM_AW-1:0]]);
        sst_pkg::REG_MSTK: next_rdat = 32'(mstk);
        sst_pkg::REG_DP: next_rdat = 32'(dp);
        default: begin
          next_rdat = ((i_wb_adr & sst_pkg::AR_MASK) == sst_pkg::REG_AR_BASE) ? 32'(ar[ar_idx]) : '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ack <= 1'b0;
      rdat <= '0;
      o_busy <= 1'b0;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
      o_busy <= next_busy;
    end
  end
  assign o_wb_ack = ack;
  assign o_wb_dat = rdat;

  // =====================================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] chk_ext;
  assign chk_ext = (is_sub_shifted_op && stat.sign_extend_select) ? {{16{dword[15]}}, dword} : {16'h0000, dword};
  logic start_sub, start_tbl;
  assign start_sub = wr && i_wb_adr == sst_pkg::REG_INSN && (next_insn.op == sst_pkg::OP_SUB_SHIFTED_OP);
  assign start_tbl = wr && i_wb_adr == sst_pkg::REG_INSN && (next_insn.op == sst_pkg::OP_TABLE_READ_OP);
  sequence s_tbl_word;
    st == sst_pkg::S_TRD ##1 st == sst_pkg::S_TWR;
  endsequence
  sequence s_tbl_close;
    st == sst_pkg::S_TEND ##1 st == sst_pkg::S_IDLE;
  endsequence

  chk_shift_sub_result: assert property (exec_sub && is_sub_shifted_op && !alu_ovf |=>
    acc == $past(acc) - ($past(chk_ext) << $past(temp_multiplicand_reg[3:0]))) else $error("shifted difference wrong");
  chk_sign_ext_high: assert property (exec_sub && is_sub_shifted_op && temp_multiplicand_reg[3:0] == '0 && !alu_ovf |=>
    acc == $past(acc) - ($past(stat.sign_extend_select) ? {{16{$past(dword[15])}}, $past(dword)} : {16'h0000, $past(dword)}))
    else $error("extension of data word wrong");
  chk_carry_borrow: assert property (exec_sub |=>
    stat.carry == ($past(acc) >= ($past(chk_ext) << $past(is_sub_shifted_op ? temp_multiplicand_reg[3:0] : 4'h0))))
    else $error("carry does not reflect borrow");
  chk_sat_clamp: assert property (exec_sub && alu_ovf && stat.saturate_on_exceed |=>
    stat.ov && (acc == sst_pkg::ACC_MAX || acc == sst_pkg::ACC_MIN)) else $error("no saturation");
  chk_unsigned_zext: assert property (exec_sub && !is_sub_shifted_op && !alu_ovf |=>
    acc == $past(acc) - {16'h0000, $past(dword)}) else $error("unsigned subtract extended sign");
  chk_direct_addr: assert property (exec_sub && !insn.ind |->
    daddr[6:0] == {insn.pointer_update_code, insn.nsel, insn.next_pointer_select}) else $error("direct address bits wrong");
  chk_next_pointer: assert property ((exec_sub || (st == sst_pkg::S_TWR && cnt == '0)) && insn.ind && insn.nsel
    |=> pointer_select == $past(insn.next_pointer_select)) else $error("pointer select not loaded");
  chk_single_time: assert property (start_sub && repeat_prefix == '0 && mcfg == '0 |=>
    st == sst_pkg::S_SUBW ##1 st == sst_pkg::S_IDLE) else $error("single subtract not one cycle");
  chk_repeat_time: assert property (start_sub && repeat_prefix == 8'h02 && mcfg == '0 |=>
    (st == sst_pkg::S_SUBW) [*3] ##1 st == sst_pkg::S_IDLE) else $error("repeat timing wrong");
  chk_tbl_pc_load: assert property (start_tbl |=>
    pc == $past(acc[15:0]) && mstk == $past(pc) + 16'h0001) else $error("table pc not loaded");
  chk_tbl_order: assert property (dwe && st != sst_pkg::S_IDLE |->
    st == sst_pkg::S_TWR && dwdata == tword) else $error("data written before program read");
  chk_tbl_single: assert property (start_tbl && repeat_prefix == '0 && mcfg == '0 |=>
    s_tbl_word ##1 s_tbl_close) else $error("single table read not three cycles");
  chk_tbl_restore: assert property (st == sst_pkg::S_TEND |=> pc == $past(mstk))
    else $error("pc not restored");
  chk_tbl_repeat_dec: assert property (st == sst_pkg::S_TWR && cnt == '0 && repeat_prefix != '0 |=>
    repeat_prefix == $past(repeat_prefix) - 8'h01 && st == sst_pkg::S_TWR) else $error("repeat count not stepped");
  chk_tbl_flags: assert property (st != sst_pkg::S_IDLE && insn.op == sst_pkg::OP_TABLE_READ_OP |=>
    stat.carry == $past(stat.carry) && stat.ov == $past(stat.ov)) else $error("table read touched flags");
endmodule

// [sim/sst_wb_host.sv]
// wishbone host model: the software side driving the register port
// assumes a classic single-cycle slave that acks within 64 clocks
module sst_wb_host (
  input wire logic i_core_clk,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat,
  input wire logic i_ack,
  input wire logic [31:0] i_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  int to_cnt = 0;
  // ====
  // idle bus from time zero
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end
  // one cycle, held until ack is sampled; a lost ack is counted, not waited on
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge i_core_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_sel <= 4'hF;
    o_dat <= wd;
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (i_ack !== 1'b1 && k < 64);
    if (i_ack !== 1'b1) to_cnt++;
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we <= 1'b0;
    o_sel <= 4'h0;
    // released address and data lines invert so a stale value is never mistaken for a request
    o_adr <= ~adr;
    o_dat <= ~wd;
  endtask
endmodule

// [sim/shifted_subtract_table_read_bench.sv]
// self-checking bench for the subtract and table-read datapath
// assumes the host model is the only driver of the register port
module shifted_subtract_table_read_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, cyc, stb, we, ack, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rv;
  logic [15:0] pw[3];
  logic [15:0] ar[8];
  logic [15:0] dm[int];
  int err_count = 0;
  int n_tests = 0;
  int ovh[4] = '{0, 1, 0, 4};
  int dwt[4] = '{0, 0, 2, 1};
  logic [10:0] cfgs[4] = '{11'h000, 11'h400, 11'h102, 11'h331};
  logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  sst_core i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .o_busy(busy));
  sst_wb_host i_host (.i_core_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
    .o_dat(wdat), .i_ack(ack), .i_dat(rdat));
  // ====
  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rv);
    chk(what, exp, rv);
  endtask
  // busy is counted from the ack edge and polled for at most 300 cycles, so a stuck busy still ends the wait
  task automatic run_insn(input logic [15:0] insn, input int exp_cyc);
    int n;
    wr(sst_pkg::REG_INSN, {16'h0, insn});
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
    chk("busy", 32'(exp_cyc), 32'(n));
  endtask
  // reference subtract: {overflow, carry, result}
  function automatic logic [33:0] sub_model(input logic [31:0] acc, input logic [15:0] d, input int sh,
      input bit sx, input bit saturate_on_exceed);
    logic [31:0] op, r;
    logic c, v;
    op = sx ? {{16{d[15]}}, d} : {16'h0, d};
    op = op << sh;
    r = acc - op;
    c = acc >= op;
    v = (acc[31] != op[31]) && (r[31] != acc[31]);
    if (v && saturate_on_exceed) r = acc[31] ? sst_pkg::ACC_MIN : sst_pkg::ACC_MAX;
    return {v, c, r};
  endfunction
  // reference pointer step; bit-reversed forms carry from the top bit down
  function automatic logic [15:0] aru_model(input logic [2:0] c, input logic [15:0] a, input logic [15:0] x);
    logic [15:0] ra, rx, t;
    ra = {<<{a}};
    rx = {<<{x}};
    case (c)
      3'h1: t = a - 16'h1;
      3'h2: t = a + 16'h1;
      3'h4: t = ra - rx;
      3'h5: t = a - x;
      3'h6: t = a + x;
      3'h7: t = ra + rx;
      default: t = a;
    endcase
    if (c == 3'h4 || c == 3'h7) t = {<<{t}};
    return t;
  endfunction
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ====
  // main sequence
  initial begin
    logic [31:0] acc, temp_multiplicand_reg;
    logic [15:0] d, pc0;
    logic [33:0] m;
    logic [3:0] fl;
    logic [2:0] next_pointer_select, pointer_select;
    logic [6:0] a7;
    bit ov, sx, saturate_on_exceed, su;
    int n, ci;
    void'($urandom(17));
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // random subtracts over the four memory timing setups, shifted on setups 0 and 2, unsigned on 1 and 3
    for (int i = 0; i < 8; i++) begin
      acc = $urandom;
      d = 16'($urandom);
      temp_multiplicand_reg = $urandom;
      sx = 1'($urandom);
      saturate_on_exceed = 1'($urandom);
      su = i[0];
      a7 = 7'($urandom);
      n = $urandom_range(3, 0) + 1;
      ci = i % 4;
      wr(sst_pkg::REG_DP, 32'(ci));
      wr(sst_pkg::REG_MADDR, {23'h0, 2'(ci), a7});
      wr(sst_pkg::REG_DDAT, {16'h0, d});
      wr(sst_pkg::REG_STAT, {30'h0, saturate_on_exceed, sx});
      wr(sst_pkg::REG_TEMP_MULTIPLICAND_REG, temp_multiplicand_reg);
      wr(sst_pkg::REG_ACC, acc);
      wr(sst_pkg::REG_RPT, 32'(n - 1));
      wr(sst_pkg::REG_MCFG, {21'h0, cfgs[ci]});
      run_insn({su ? sst_pkg::OP_SUB_UNSIGNED_OP : sst_pkg::OP_SUB_SHIFTED_OP, 1'b0, a7}, ovh[ci] + n * (1 + dwt[ci]));
      ov = 1'b0;
      for (int k = 0; k < n; k++) begin
        m = sub_model(acc, d, su ? 0 : int'(temp_multiplicand_reg[3:0]), sx && !su, saturate_on_exceed);
        acc = m[31:0];
        ov |= m[33];
      end
      rc("acc", sst_pkg::REG_ACC, acc);
      rc("stat", sst_pkg::REG_STAT, {28'h0, ov, m[32], saturate_on_exceed, sx});
      rc("rpt", sst_pkg::REG_RPT, 32'h0);
    end
    // indirect table reads, one to three words, through every update code
    wr(sst_pkg::REG_MCFG, 32'h0);
    foreach (codes[j]) begin
      acc = $urandom;
      pc0 = 16'($urandom_range(254, 0));
      pointer_select = 3'($urandom_range(7, 1));
      next_pointer_select = 3'($urandom);
      fl = 4'($urandom);
      n = j % 3 + 1;
      for (int k = 0; k < n; k++) begin
        pw[k] = 16'($urandom);
        wr(sst_pkg::REG_MADDR, {24'h0, 8'(acc[7:0] + k)});
        wr(sst_pkg::REG_PDAT, {16'h0, pw[k]});
      end
      for (int k = 0; k < 8; k++) begin
        ar[k] = 16'($urandom);
        wr(8'(sst_pkg::REG_AR_BASE + 4 * k), {16'h0, ar[k]});
      end
      wr(sst_pkg::REG_ARP, {29'h0, pointer_select});
      wr(sst_pkg::REG_STAT, {28'h0, fl});
      wr(sst_pkg::REG_ACC, acc);
      wr(sst_pkg::REG_RPT, 32'(n - 1));
      wr(sst_pkg::REG_PC, {16'h0, pc0});
      run_insn({sst_pkg::OP_TABLE_READ_OP, 1'b1, codes[j], codes[j][0], next_pointer_select}, n + 2);
      dm.delete();
      for (int k = 0; k < n; k++) begin
        dm[ar[pointer_select][8:0]] = pw[k];
        ar[pointer_select] = aru_model(codes[j], ar[pointer_select], ar[0]);
        if (codes[j][0]) pointer_select = next_pointer_select;
      end
      foreach (dm[a]) begin
        wr(sst_pkg::REG_MADDR, 32'(a));
        rc("dmem", sst_pkg::REG_DDAT, {16'h0, dm[a]});
      end
      for (int k = 0; k < 8; k++) begin
        rc("ar", 8'(sst_pkg::REG_AR_BASE + 4 * k), {16'h0, ar[k]});
      end
      rc("arp", sst_pkg::REG_ARP, {29'h0, pointer_select});
      rc("pc", sst_pkg::REG_PC, {16'h0, pc0 + 16'h1});
      rc("mstk", sst_pkg::REG_MSTK, {16'h0, pc0 + 16'h1});
      rc("flags", sst_pkg::REG_STAT, {28'h0, fl});
      rc("acc kept", sst_pkg::REG_ACC, acc);
    end
    // unknown opcode is refused; unmapped space reads zero
    run_insn(16'hFF00, 0);
    rc("illegal", sst_pkg::REG_STAT, {26'h0, 2'h2, fl});
    rc("unmapped", 8'h3C, 32'h0);
    chk("timeouts", 32'h0, 32'(i_host.to_cnt));
    summarize();
  end
endmodule
